/* pkg/ssm_pkg.sv */
package ssm_pkg;

  // Register byte offsets (low address byte decoded)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INSTR  = 8'h04;
  localparam logic [7:0] OFS_DADDR  = 8'h08;
  localparam logic [7:0] OFS_PC     = 8'h0c;
  localparam logic [7:0] OFS_SP     = 8'h10;
  localparam logic [7:0] OFS_LINK   = 8'h14;
  localparam logic [7:0] OFS_CC     = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // Field positions
  localparam int unsigned CTRL_START    = 0;
  localparam int unsigned CTRL_CLR_DONE = 1;
  localparam int unsigned STAT_BUSY     = 0;
  localparam int unsigned STAT_DONE     = 1;
  localparam int unsigned STAT_ILLEGAL  = 2;
  localparam int unsigned CC_N          = 3;
  localparam int unsigned CC_Z          = 2;
  localparam int unsigned CC_V          = 1;
  localparam int unsigned CC_C          = 0;

  // Reset values
  localparam logic [15:0] RST_PC   = 16'h0000;
  localparam logic [15:0] RST_SP   = 16'h0000;
  localparam logic [15:0] RST_LINK = 16'h0000;
  localparam logic [3:0]  RST_CC   = 4'h0;

  localparam logic [15:0] WORD_STEP   = 16'h0002;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Opcodes, instruction bits 15:6
  localparam logic [9:0] OPC_SHRB    = 10'h232;
  localparam logic [9:0] OPC_SHLW    = 10'h033;
  localparam logic [9:0] OPC_SHLB    = 10'h233;
  localparam logic [9:0] OPC_MARK    = 10'h034;
  localparam logic [9:0] OPC_FROM_PI = 10'h035;
  localparam logic [9:0] OPC_FROM_PD = 10'h235;
  localparam logic [9:0] OPC_TO_PI   = 10'h036;

  typedef enum logic [2:0] {
    K_NONE    = 3'b000,
    K_SHRB    = 3'b001,
    K_SHLW    = 3'b010,
    K_SHLB    = 3'b011,
    K_MARK    = 3'b100,
    K_FROM_PI = 3'b101,
    K_FROM_PD = 3'b110,
    K_TO_PI   = 3'b111
  } ssm_kind_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_LOAD  = 2'b01,
    S_STORE = 2'b10
  } ssm_state_t;

  function automatic ssm_kind_t ssm_decode(input logic [15:0] ir);
    ssm_kind_t k;
    k = K_NONE;
    case (ir[15:6])
      OPC_SHRB:    k = K_SHRB;
      OPC_SHLW:    k = K_SHLW;
      OPC_SHLB:    k = K_SHLB;
      OPC_MARK:    k = K_MARK;
      OPC_FROM_PI: k = K_FROM_PI;
      OPC_FROM_PD: k = K_FROM_PD;
      OPC_TO_PI:   k = K_TO_PI;
      default:     k = K_NONE;
    endcase
    return k;
  endfunction

endpackage

/* pkg/ssm_alu_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ssm_alu_if;
  import ssm_pkg::*;
  ssm_kind_t   kind;
  logic [15:0] operand;
  logic [3:0]  cc_in;
  logic [15:0] result;
  logic [3:0]  cc_out;
  modport ctrl (output kind, output operand, output cc_in, input result, input cc_out);
  modport alu  (input kind, input operand, input cc_in, output result, output cc_out);
endinterface
`default_nettype wire

/* src/ssm_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module ssm_alu
  import ssm_pkg::*;
(
  // Operand and flags in, result and flags out
  ssm_alu_if.alu bus
);

  logic [7:0] r8;
  logic [15:0] r16;

  always_comb begin
    r8         = 8'h00;
    r16        = 16'h0000;
    bus.result = bus.operand;
    bus.cc_out = bus.cc_in;
    case (bus.kind)
      K_SHRB: begin
        r8                 = {bus.operand[7], bus.operand[7:1]};
        bus.result         = {8'h00, r8};
        bus.cc_out[CC_C]   = bus.operand[0];
        bus.cc_out[CC_N]   = r8[7];
        bus.cc_out[CC_Z]   = (r8 == 8'h00);
        bus.cc_out[CC_V]   = r8[7] ^ bus.operand[0];
      end
      K_SHLW: begin
        r16                = {bus.operand[15], bus.operand[13:0], 1'b0};
        bus.result         = r16;
        bus.cc_out[CC_C]   = bus.operand[14];
        bus.cc_out[CC_N]   = r16[15];
        bus.cc_out[CC_Z]   = (r16 == 16'h0000);
        bus.cc_out[CC_V]   = r16[15] ^ bus.operand[14];
      end
      K_SHLB: begin
        r8                 = {bus.operand[7], bus.operand[5:0], 1'b0};
        bus.result         = {8'h00, r8};
        bus.cc_out[CC_C]   = bus.operand[6];
        bus.cc_out[CC_N]   = r8[7];
        bus.cc_out[CC_Z]   = (r8 == 8'h00);
        bus.cc_out[CC_V]   = r8[7] ^ bus.operand[6];
      end
      K_FROM_PI, K_FROM_PD, K_TO_PI: begin
        // Carry is left alone on purpose
        bus.cc_out[CC_N]   = bus.operand[15];
        bus.cc_out[CC_Z]   = (bus.operand == 16'h0000);
        bus.cc_out[CC_V]   = 1'b0;
      end
      default: begin
        bus.result = bus.operand;
      end
    endcase
  end

endmodule
`default_nettype wire

/* src/ssm_top.sv */
// What this block does
// - The byte right shift keeps bit 7, puts old bit 0 in carry, sets N, Z and V as N xor C, and writes back.
// - The word left shift builds its result from bit 15, bits 13 to 0 moved up, and a zero in bit 0.
// - The word left shift puts old bit 14 into carry.
// - The word left shift takes N from result bit 15 and sets Z only for a zero result.
// - The word left shift then sets V to N xor C and stores the result to the destination.
// - The byte left shift keeps bit 7, moves bits 5 to 0 up, puts bit 6 in carry, and sets N, Z and V.
// - The frame unwind sets the stack pointer to PC plus 2 plus twice the six-bit count.
// - The frame unwind then copies the link register into the PC.
// - The frame unwind finally pops the word at the stack pointer into the link register.
// - The move from previous instruction space reads it there, drops SP by 2 and pushes in current space.
// - The move from previous data space reads it there, drops SP by 2 and pushes in current space.
// - Both moves from previous space set N and Z from the word and clear V.
// - The move to previous instruction space pops from the current stack and stores in previous space.
// - The move to previous instruction space sets N and Z from the popped word and clears V.
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ssm_top
  import ssm_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Memory and mapping unit
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_byte,
  output logic             mem_prev,
  output logic             mem_dspace,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  output logic [5:0]       mem_dst_spec,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata
);

  typedef struct packed {
    ssm_state_t  st;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] link;
    logic [15:0] instr;
    logic [15:0] daddr;
    logic [15:0] op;
    logic [3:0]  cc;
    logic        done;
    logic        illegal;
    logic        req;
    logic        we;
    logic        byte_op;
    logic        prev;
    logic        dspace;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [5:0]  spec;
    logic        aw_have;
    logic [7:0]  awaddr;
    logic        w_have;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } ssm_top_state_t;

  ssm_top_state_t q;
  ssm_top_state_t d;
  ssm_kind_t      kind;
  logic           start;
  logic           clr;
  logic           ld_ack;
  logic [15:0]    rd_q;
  logic [3:0]     cc_q;

  ssm_alu_if alu_bus ();

  ssm_alu u_alu (
    .bus (alu_bus.alu)
  );

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] ws);
    return {ws[1] ? wd[15:8] : old[15:8], ws[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic is_byte(input ssm_kind_t k);
    return (k == K_SHRB) || (k == K_SHLB);
  endfunction

  assign kind            = ssm_decode(q.instr);
  assign ld_ack          = (q.st == S_LOAD) && q.req && mem_ack;
  assign alu_bus.kind    = kind;
  assign alu_bus.operand = mem_rdata;
  assign alu_bus.cc_in   = q.cc;

  always_comb begin
    d     = q;
    start = 1'b0;
    clr   = 1'b0;
    // Write channel capture, either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wd     = s_axi_wdata;
      d.ws     = s_axi_wstrb;
    end
    if (s_axi_bready && q.bvalid) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      // Machine state is frozen to software while an instruction runs
      if (q.awaddr == OFS_CTRL) begin
        start = q.ws[0] & q.wd[CTRL_START];
        clr   = q.ws[0] & q.wd[CTRL_CLR_DONE];
      end else if (q.awaddr == OFS_INSTR) begin
        if (q.st == S_IDLE) d.instr = merge16(q.instr, q.wd[15:0], q.ws[1:0]);
      end else if (q.awaddr == OFS_DADDR) begin
        if (q.st == S_IDLE) d.daddr = merge16(q.daddr, q.wd[15:0], q.ws[1:0]);
      end else if (q.awaddr == OFS_PC) begin
        if (q.st == S_IDLE) d.pc = merge16(q.pc, q.wd[15:0], q.ws[1:0]);
      end else if (q.awaddr == OFS_SP) begin
        if (q.st == S_IDLE) d.sp = merge16(q.sp, q.wd[15:0], q.ws[1:0]);
      end else if (q.awaddr == OFS_LINK) begin
        if (q.st == S_IDLE) d.link = merge16(q.link, q.wd[15:0], q.ws[1:0]);
      end else if (q.awaddr == OFS_CC) begin
        if (q.st == S_IDLE && q.ws[0]) d.cc = q.wd[3:0];
      end else if (q.awaddr == OFS_STATUS) begin
        d.bresp = RESP_OKAY;
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end
    // Read channel
    if (s_axi_rready && q.rvalid) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      if (s_axi_araddr[7:0] == OFS_CTRL) begin
        d.rdata = 32'h0000_0000;
      end else if (s_axi_araddr[7:0] == OFS_INSTR) begin
        d.rdata[15:0] = q.instr;
      end else if (s_axi_araddr[7:0] == OFS_DADDR) begin
        d.rdata[15:0] = q.daddr;
      end else if (s_axi_araddr[7:0] == OFS_PC) begin
        d.rdata[15:0] = q.pc;
      end else if (s_axi_araddr[7:0] == OFS_SP) begin
        d.rdata[15:0] = q.sp;
      end else if (s_axi_araddr[7:0] == OFS_LINK) begin
        d.rdata[15:0] = q.link;
      end else if (s_axi_araddr[7:0] == OFS_CC) begin
        d.rdata[3:0] = q.cc;
      end else if (s_axi_araddr[7:0] == OFS_STATUS) begin
        d.rdata[STAT_BUSY]    = (q.st != S_IDLE);
        d.rdata[STAT_DONE]    = q.done;
        d.rdata[STAT_ILLEGAL] = q.illegal;
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end
    // Completion below sets done after this clear, so a set wins
    if (clr) d.done = 1'b0;
    case (q.st)
      S_IDLE: begin
        if (start) begin
          d.done    = 1'b0;
          d.illegal = 1'b0;
          if (kind == K_NONE) begin
            d.illegal = 1'b1;
            d.done    = 1'b1;
          end else if (kind == K_MARK) begin
            d.sp = 16'(q.pc + WORD_STEP + {9'h000, q.instr[5:0], 1'b0});
            d.pc = q.link;
            d.st = S_LOAD;
          end else begin
            d.st = S_LOAD;
          end
        end
      end
      S_LOAD: begin
        if (!q.req) begin
          // Request stays up until the acknowledge; a new one needs a low cycle
          d.req     = 1'b1;
          d.we      = 1'b0;
          d.spec    = q.instr[5:0];
          d.byte_op = is_byte(kind);
          d.prev    = (kind == K_FROM_PI) || (kind == K_FROM_PD);
          d.dspace  = (kind != K_FROM_PI);
          d.addr    = ((kind == K_MARK) || (kind == K_TO_PI)) ? q.sp : q.daddr;
        end else if (mem_ack) begin
          d.req = 1'b0;
          d.op  = alu_bus.result;
          d.cc  = alu_bus.cc_out;
          d.st  = S_STORE;
          case (kind)
            K_MARK: begin
              d.link = mem_rdata;
              d.sp   = 16'(q.sp + WORD_STEP);
              d.st   = S_IDLE;
              d.done = 1'b1;
            end
            K_FROM_PI, K_FROM_PD: d.sp = 16'(q.sp - WORD_STEP);
            K_TO_PI: d.sp = 16'(q.sp + WORD_STEP);
            default: d.sp = q.sp;
          endcase
        end
      end
      S_STORE: begin
        if (!q.req) begin
          d.req     = 1'b1;
          d.we      = 1'b1;
          d.wdata   = q.op;
          d.spec    = q.instr[5:0];
          d.byte_op = is_byte(kind);
          d.prev    = (kind == K_TO_PI);
          d.dspace  = (kind != K_TO_PI);
          d.addr    = ((kind == K_FROM_PI) || (kind == K_FROM_PD)) ? q.sp : q.daddr;
        end else if (mem_ack) begin
          d.req  = 1'b0;
          d.we   = 1'b0;
          d.st   = S_IDLE;
          d.done = 1'b1;
        end
      end
      default: d.st = S_IDLE;
    endcase
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q      <= '0;
      q.pc   <= RST_PC;
      q.sp   <= RST_SP;
      q.link <= RST_LINK;
      q.cc   <= RST_CC;
    end else begin
      q <= d;
    end
  end

  // Only the checks below read these
  always_ff @(posedge aclk) begin
    rd_q <= mem_rdata;
    cc_q <= q.cc;
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rvalid  = q.rvalid;
  assign mem_req       = q.req;
  assign mem_we        = q.we;
  assign mem_byte      = q.byte_op;
  assign mem_prev      = q.prev;
  assign mem_dspace    = q.dspace;
  assign mem_addr      = q.addr;
  assign mem_wdata     = q.wdata;
  assign mem_dst_spec  = q.spec;

  a_shrb_shift: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && kind == K_SHRB) |=> (q.op[7:0] == {rd_q[7], rd_q[7:1]}) && (q.cc[CC_C] == rd_q[0])
      && (q.cc[CC_V] == (q.cc[CC_N] ^ q.cc[CC_C])) && (q.cc[CC_Z] == (q.op[7:0] == 8'h00)))
    else $error("byte right shift result or flags wrong");

  a_shlw_result: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && kind == K_SHLW) |=> q.op == {rd_q[15], rd_q[13:0], 1'b0})
    else $error("word left shift result wrong");

  a_shlw_carry: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && kind == K_SHLW) |=> q.cc[CC_C] == rd_q[14])
    else $error("word left shift carry wrong");

  a_shlw_nz_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && kind == K_SHLW) |=> (q.cc[CC_N] == rd_q[15]) && (q.cc[CC_Z] == ({rd_q[15], rd_q[13:0]} == 15'h0000)))
    else $error("word left shift N or Z wrong");

  a_shlw_v_store: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && kind == K_SHLW) |=> (q.cc[CC_V] == (q.cc[CC_N] ^ q.cc[CC_C]))
      ##1 (mem_req && mem_we && mem_addr == q.daddr && mem_wdata == q.op))
    else $error("word left shift V or store wrong");

  a_shlb_shift: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && kind == K_SHLB) |=> (q.op[7:0] == {rd_q[7], rd_q[5:0], 1'b0}) && (q.cc[CC_C] == rd_q[6])
      && (q.cc[CC_N] == rd_q[7]) && (q.cc[CC_V] == (rd_q[7] ^ rd_q[6])))
    else $error("byte left shift result or flags wrong");

  a_mark_sp_pc: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == S_IDLE && start && kind == K_MARK) |=> (q.pc == $past(q.link))
      && (q.sp == 16'($past(q.pc) + WORD_STEP + {9'h000, q.instr[5:0], 1'b0})))
    else $error("frame unwind SP or PC wrong");

  a_mark_pop: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && kind == K_MARK) |-> (mem_addr == q.sp && !mem_prev)
      ##1 (q.link == rd_q && q.sp == 16'($past(q.sp) + WORD_STEP) && q.st == S_IDLE))
    else $error("frame unwind pop wrong");

  a_from_pi_push: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && kind == K_FROM_PI) |-> (mem_prev && !mem_dspace) ##1 (q.sp == 16'($past(q.sp) - WORD_STEP))
      ##1 (mem_req && mem_we && !mem_prev && mem_addr == q.sp))
    else $error("move from previous I space wrong");

  a_from_pd_push: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && kind == K_FROM_PD) |-> (mem_prev && mem_dspace) ##1 (q.sp == 16'($past(q.sp) - WORD_STEP))
      ##1 (mem_req && mem_we && !mem_prev && mem_addr == q.sp))
    else $error("move from previous D space wrong");

  a_move_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && (kind == K_FROM_PI || kind == K_FROM_PD || kind == K_TO_PI)) |=> (q.cc[CC_N] == rd_q[15])
      && (q.cc[CC_Z] == (rd_q == 16'h0000)) && !q.cc[CC_V] && (q.cc[CC_C] == cc_q[CC_C]))
    else $error("previous space move flags wrong");

  a_to_pi_pop: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_ack && kind == K_TO_PI) |-> (mem_addr == q.sp && !mem_prev) ##1 (q.sp == 16'($past(q.sp) + WORD_STEP))
      ##1 (mem_req && mem_we && mem_prev && !mem_dspace && mem_addr == q.daddr))
    else $error("move to previous I space wrong");

  a_space_spec: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_req && q.st == S_LOAD) |-> (mem_dst_spec == q.instr[5:0])
      && (mem_prev == (kind == K_FROM_PI || kind == K_FROM_PD)))
    else $error("space selector or specifier wrong");

endmodule
`default_nettype wire

/* tb/ssm_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ssm_mem_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Request from the block
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_byte,
  input  wire logic        mem_prev,
  input  wire logic        mem_dspace,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  // Answer and pacing
  input  wire logic [2:0]  wait_cycles,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] mem [0:511];
  logic [2:0]  cnt_q;
  logic [8:0]  ix;
  // Each space gets its own words, so a wrong space selector shows up as wrong data
  assign ix = {mem_prev, mem_dspace, mem_addr[7:1]};
  // Plain always, since the bench preloads words into the array directly
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_ack <= 1'b0;
      cnt_q <= 3'h0;
      mem_rdata <= 16'h5a5a;
    end else if (mem_req && !mem_ack && cnt_q >= wait_cycles) begin
      mem_ack <= 1'b1;
      cnt_q <= 3'h0;
      mem_rdata <= mem[ix];
      if (mem_we) begin
        mem[ix] <= mem_byte ? {mem[ix][15:8], mem_wdata[7:0]} : mem_wdata;
      end
    end else begin
      mem_ack <= 1'b0;
      cnt_q <= (mem_req && !mem_ack) ? cnt_q + 3'h1 : 3'h0;
      // Outside the ack cycle the data lines invert every cycle, so the last word never shows two cycles running
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

/* tb/shift_and_stack_move_execution_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module shift_and_stack_move_execution_tb_top;
  import ssm_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, mem_ack;
  logic        arvalid, arready, rvalid, rready, mem_req, mem_we, mem_byte, mem_prev, mem_dspace;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, last_resp;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [5:0]  mem_dst_spec, cur_spec;
  logic [2:0]  wait_cycles;
  logic [31:0] seed = 32'hd9c7;
  logic [15:0] corner [6] = '{16'h4000, 16'hc000, 16'h0080, 16'h0001, 16'h4000, 16'h0040};
  int          err_count = 0;
  int          compares = 0;

  ssm_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req(mem_req),
    .mem_we(mem_we), .mem_byte(mem_byte), .mem_prev(mem_prev), .mem_dspace(mem_dspace),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_dst_spec(mem_dst_spec), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  ssm_mem_model i_mem (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_byte(mem_byte), .mem_prev(mem_prev), .mem_dspace(mem_dspace), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .wait_cycles(wait_cycles), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [8:0] ix(input logic p, input logic d, input logic [15:0] a);
    return {p, d, a[7:1]};
  endfunction

  function automatic logic [19:0] exp_shift(input logic [9:0] opc, input logic [15:0] d);
    logic [15:0] r;
    logic        c;
    logic        n;
    logic        z;
    if (opc == OPC_SHRB) begin
      r = {d[15:8], d[7], d[7:1]};
      c = d[0];
    end else if (opc == OPC_SHLW) begin
      r = {d[15], d[13:0], 1'b0};
      c = d[14];
    end else begin
      r = {d[15:8], d[7], d[5:0], 1'b0};
      c = d[6];
    end
    n = (opc == OPC_SHLW) ? r[15] : r[7];
    z = (opc == OPC_SHLW) ? r == 16'h0000 : r[7:0] == 8'h00;
    return {r, n, z, n ^ c, c};
  endfunction

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic hang();
    err_count++;
    $display("mismatch at %0t: wait ran out", $time);
    wrap_up();
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge aclk);
    awaddr <= {24'h0000_00, a};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    if (n == 50) hang();
    last_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= {24'h0000_00, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    if (n == 50) hang();
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic run(input logic [15:0] ir);
    logic [31:0] s;
    int          n;
    cur_spec <= ir[5:0];
    wait_cycles <= 3'(rnd());
    wr(OFS_INSTR, ir);
    wr(OFS_CTRL, 16'h0001);
    for (n = 0; n < 50; n++) begin
      rd(OFS_STATUS, s);
      if (s[STAT_DONE] === 1'b1) break;
    end
    if (n == 50) hang();
  endtask

  // The operand specifier must follow the instruction on every access
  always @(posedge aclk) begin
    if (mem_req === 1'b1) begin
      compares++;
      if (mem_dst_spec !== cur_spec) begin
        err_count++;
        $display("mismatch at %0t: operand specifier %h", $time, mem_dst_spec);
      end
    end
  end

  initial begin
    logic [31:0] v;
    logic [15:0] d, a, sp, pc, lk, w;
    logic [3:0]  cc;
    logic [19:0] e;
    logic [9:0]  opc;
    logic [8:0]  t;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    wait_cycles = 3'h0;
    cur_spec = 6'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 3; i < 8; i++) begin
      rd(8'(4 * i), v);
      chk(v[15:0], 16'h0000);
    end
    wr(8'h20, 16'hffff);
    chk(16'(last_resp), 16'(RESP_SLVERR));
    rd(8'h24, v);
    chk(16'(last_resp), 16'(RESP_SLVERR));
    $display("reset and map test done");
    for (int i = 0; i < 30; i++) begin
      opc = (i % 3 == 0) ? OPC_SHRB : (i % 3 == 1) ? OPC_SHLW : OPC_SHLB;
      d = (i < 6) ? corner[i] : 16'(rnd());
      a = 16'(rnd()) & 16'h00fe;
      cc = 4'(rnd());
      i_mem.mem[ix(0, 1, a)] = d;
      wr(OFS_DADDR, a);
      wr(OFS_CC, {12'h000, cc});
      run({opc, 6'(rnd())});
      e = exp_shift(opc, d);
      chk(i_mem.mem[ix(0, 1, a)], e[19:4]);
      rd(OFS_CC, v);
      chk(v[15:0], {12'h000, e[3:0]});
    end
    $display("shift test done");
    for (int j = 0; j < 3; j++) begin
      d = (j == 0) ? 16'h003f : (j == 1) ? 16'h0000 : 16'(rnd()) & 16'h003f;
      pc = 16'(rnd()) & 16'hfffe;
      lk = 16'(rnd());
      w = 16'(rnd());
      sp = pc + 16'h0002 + (d << 1);
      i_mem.mem[ix(0, 1, sp)] = w;
      wr(OFS_PC, pc);
      wr(OFS_LINK, lk);
      run({OPC_MARK, d[5:0]});
      rd(OFS_SP, v);
      chk(v[15:0], sp + 16'h0002);
      rd(OFS_PC, v);
      chk(v[15:0], lk);
      rd(OFS_LINK, v);
      chk(v[15:0], w);
    end
    $display("frame unwind test done");
    for (int k = 0; k < 9; k++) begin
      opc = (k % 3 == 0) ? OPC_FROM_PI : (k % 3 == 1) ? OPC_FROM_PD : OPC_TO_PI;
      w = (k < 3) ? 16'h0000 : (k < 6) ? 16'h8000 : 16'(rnd());
      a = 16'(rnd()) & 16'hfffe;
      sp = 16'(rnd()) & 16'hfffe;
      cc = 4'(rnd());
      t = (opc == OPC_TO_PI) ? ix(1, 0, a) : ix(0, 1, sp - 16'h0002);
      i_mem.mem[t] = ~w;
      if (opc == OPC_TO_PI) i_mem.mem[ix(0, 1, sp)] = w;
      else i_mem.mem[ix(1, opc == OPC_FROM_PD, a)] = w;
      wr(OFS_DADDR, a);
      wr(OFS_SP, sp);
      wr(OFS_CC, {12'h000, cc});
      run({opc, 6'(rnd())});
      rd(OFS_SP, v);
      chk(v[15:0], (opc == OPC_TO_PI) ? sp + 16'h0002 : sp - 16'h0002);
      chk(i_mem.mem[t], w);
      rd(OFS_CC, v);
      chk(v[15:0], {12'h000, w[15], w == 16'h0000, 1'b0, cc[0]});
    end
    $display("previous space test done");
    // An undecoded opcode finishes at once; clear-done must leave the illegal flag
    run(16'h0000);
    rd(OFS_STATUS, v);
    chk(v[15:0], 16'((1 << STAT_DONE) | (1 << STAT_ILLEGAL)));
    wr(OFS_CTRL, 16'(1 << CTRL_CLR_DONE));
    rd(OFS_STATUS, v);
    chk(v[15:0], 16'(1 << STAT_ILLEGAL));
    $display("illegal opcode test done");
    wrap_up();
  end
endmodule
`default_nettype wire
